/* verilog/acc_clk_consts.svh */
// constants for the audio codec clock control block
// assumes nothing; included by the package, the clock control file and the bench
`ifndef ACC_CLK_CONSTS_SVH
`define ACC_CLK_CONSTS_SVH

// -----------------------------------------------------------------
// register offsets (printed word addresses of the control port)
// -----------------------------------------------------------------
`define ACC_DIV_CTRL_OFS      8'h28
`define ACC_ROUTE_CTRL_OFS    8'h29

// -----------------------------------------------------------------
// divider control field positions
// -----------------------------------------------------------------
`define ACC_TICK_EN_BIT       15
`define ACC_TICK_RATE_BIT     14
`define ACC_SRC_SEL_BIT       11
`define ACC_PREDIV_BIT        8
`define ACC_BCLK_MSB          7
`define ACC_BCLK_LSB          4
`define ACC_AUX_MSB           2
`define ACC_AUX_LSB           0

// -----------------------------------------------------------------
// routing control field positions
// -----------------------------------------------------------------
`define ACC_FRAME_SEL_BIT     15
`define ACC_MCLK_DIR_BIT      0

// -----------------------------------------------------------------
// reset values and writable masks
// -----------------------------------------------------------------
`define ACC_DIV_CTRL_RST      16'h0040
`define ACC_DIV_CTRL_MASK     16'hC9F7
`define ACC_ROUTE_CTRL_RST    16'h0000
`define ACC_ROUTE_CTRL_MASK   16'h8001

// -----------------------------------------------------------------
// slow tick division ratios, in codec system clock periods
// -----------------------------------------------------------------
`define ACC_TICK_SLOW_DIV     2097152
`define ACC_TICK_FAST_DIV     524288
`define ACC_TICK_W            22

`endif

/* verilog/acc_pkg.sv */
// types shared by the codec clock control design files
// assumes the constants header is on the include path
package acc_pkg;
  `include "acc_clk_consts.svh"

  // phase length of a divided clock, in codec clock half periods
  typedef logic [5:0] acc_len_t;

  // codec system clock source
  typedef enum logic {
    acc_src_pin,
    acc_src_loop
  } acc_src_t;
endpackage : acc_pkg

/* verilog/acc_frac_div.sv */
// phase-length clock divider for the codec clock control block
// assumes evt is a one-cycle pulse on each codec clock half period
module acc_frac_div (
  // clock and reset
  input  wire logic           core_clk,
  input  wire logic           rst,
  // control
  input  wire logic           run,
  input  wire logic           evt,
  input  wire acc_pkg::acc_len_t hi_len,
  input  wire acc_pkg::acc_len_t lo_len,
  // divided clock
  output logic                clk_out
);
  import acc_pkg::*;

  // -----------------------------------------------------------------
  // phase counter
  // -----------------------------------------------------------------
  acc_len_t cnt;                 // events spent in the current phase
  acc_len_t next_cnt;            // counter after this event
  wire acc_len_t cur_len = clk_out ? hi_len : lo_len;  // phase length now
  wire phase_end = evt && (cnt == cur_len - 6'h01);    // last event of phase

  assign next_cnt = phase_end ? 6'h00 : cnt + 6'h01;

  // unequal high and low lengths give the half-step ratios
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt     <= 6'h00;
      clk_out <= 1'b0;
    end else if (!run) begin
      // held low while stopped so restart is phase aligned
      cnt     <= 6'h00;
      clk_out <= 1'b0;
    end else if (evt) begin
      cnt     <= next_cnt;
      clk_out <= clk_out ^ phase_end;
    end
  end

  // -----------------------------------------------------------------
  // checks: each finished phase lasted exactly its programmed length
  // -----------------------------------------------------------------
  acc_len_t ast_evts;            // events seen since the last toggle
  logic     ast_stable;          // lengths unchanged through the phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ast_evts   <= 6'h00;
      ast_stable <= 1'b0;
    end else if (!run || (clk_out != $past(clk_out))) begin
      ast_evts   <= evt ? 6'h01 : 6'h00;
      ast_stable <= run;
    end else begin
      ast_evts   <= evt ? ast_evts + 6'h01 : ast_evts;
      ast_stable <= ast_stable && $stable(hi_len) && $stable(lo_len);
    end
  end

  AST_PHASE_LEN: assert property (@(posedge core_clk) disable iff (rst)
    (run && $past(run) && ast_stable && $changed(clk_out))
      |-> ast_evts == ($past(clk_out) ? $past(hi_len) : $past(lo_len)))
    else $error("divided clock phase length wrong");
endmodule : acc_frac_div

/* verilog/acc_clock_control.sv */
// codec clock selection, bit clock, aux clock and slow tick generation
// assumes clock pins are sampled here; frame clocks and mode come from core logic
//
// Contract
// - slow tick runs only while enabled
// - tick rate is system clock over 2^21 or 2^19
// - system clock from pin or loop by select
// - slave pin clock optionally halved
// - bit clock divider, reset divide by four
// - aux clock ratios, two codes reserved
// - master frame pin from playback or record
// - master clock pin direction from register
`include "acc_clk_consts.svh"
module acc_clock_control #(
  parameter int SLOW_DIV = `ACC_TICK_SLOW_DIV,
  parameter int FAST_DIV = `ACC_TICK_FAST_DIV,
  parameter int TICK_W   = `ACC_TICK_W
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // clock sources
  input  wire logic        mclk_in,
  input  wire logic        frequency_locked_loop,
  // master clock pin drive
  output logic             mclk_out,
  output logic             mclk_oe,
  // serial audio clocks
  input  wire logic        master_mode,
  input  wire logic        playback_frame_clock,
  input  wire logic        record_frame_clock,
  output logic             bclk_out,
  output logic             bclk_oe,
  output logic             frame_clk_out,
  output logic             frame_clk_oe,
  // derived clocks
  output logic             codec_system_clock,
  output logic             aux_output_clock,
  output logic             slow_tick
);
  import acc_pkg::*;

  if (FAST_DIV < 2 || SLOW_DIV < 2 || SLOW_DIV > (1 << TICK_W) || FAST_DIV > (1 << TICK_W)) begin : g_chk
    $error("slow tick divisors do not fit the tick counter");
  end

  // -----------------------------------------------------------------
  // control registers
  // -----------------------------------------------------------------
  logic [15:0] codec_clock_divider_control;   // tick, source, dividers
  logic [15:0] codec_clock_routing_control;   // frame select, pin direction
  wire hit_div   = reg_addr == `ACC_DIV_CTRL_OFS;
  wire hit_route = reg_addr == `ACC_ROUTE_CTRL_OFS;

  wire       slow_tick_enable   = codec_clock_divider_control[`ACC_TICK_EN_BIT];
  wire       slow_tick_rate     = codec_clock_divider_control[`ACC_TICK_RATE_BIT];
  wire       prediv             = codec_clock_divider_control[`ACC_PREDIV_BIT];
  wire [3:0] bclk_code          = codec_clock_divider_control[`ACC_BCLK_MSB:`ACC_BCLK_LSB];
  wire [2:0] aux_output_clock_divider = codec_clock_divider_control[`ACC_AUX_MSB:`ACC_AUX_LSB];
  wire       frame_clock_record_select = codec_clock_routing_control[`ACC_FRAME_SEL_BIT];
  wire       mclk_dir           = codec_clock_routing_control[`ACC_MCLK_DIR_BIT];
  wire acc_src_t src_sel = acc_src_t'(codec_clock_divider_control[`ACC_SRC_SEL_BIT]);

  // writes store only defined bits so reserved bits read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      codec_clock_divider_control <= `ACC_DIV_CTRL_RST;
      codec_clock_routing_control <= `ACC_ROUTE_CTRL_RST;
    end else if (reg_wr && hit_div) begin
      codec_clock_divider_control <= reg_wdata & `ACC_DIV_CTRL_MASK;
    end else if (reg_wr && hit_route) begin
      codec_clock_routing_control <= reg_wdata & `ACC_ROUTE_CTRL_MASK;
    end
  end

  // read data registered; unmapped offsets return zero
  wire [15:0] next_rdata = hit_div   ? codec_clock_divider_control :
                           hit_route ? codec_clock_routing_control : 16'h0000;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // -----------------------------------------------------------------
  // source synchronisers and edge detect
  // -----------------------------------------------------------------
  logic [1:0] pin_sync;          // master clock pin, two stages
  logic [1:0] loop_sync;         // loop output, two stages
  logic       pin_last;          // previous synchronised pin level
  logic       loop_last;         // previous synchronised loop level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_sync  <= 2'h0;
      loop_sync <= 2'h0;
      pin_last  <= 1'b0;
      loop_last <= 1'b0;
    end else begin
      pin_sync  <= {pin_sync[0], mclk_in};
      loop_sync <= {loop_sync[0], frequency_locked_loop};
      pin_last  <= pin_sync[1];
      loop_last <= loop_sync[1];
    end
  end

  // the pin only feeds the clock while it is an input, avoiding a loop
  wire pin_lvl   = pin_sync[1] && !mclk_dir;
  wire pin_prev  = pin_last && !mclk_dir;
  wire src_lvl   = (src_sel == acc_src_loop) ? loop_sync[1] : pin_lvl;
  wire src_prev  = (src_sel == acc_src_loop) ? loop_last : pin_prev;
  wire src_edge  = src_lvl != src_prev;
  wire src_rise  = src_lvl && !src_prev;

  // halving toggles the system clock on source rises only
  wire sys_evt   = prediv ? src_rise : src_edge;
  wire sys_rise  = sys_evt && !codec_system_clock;

  // system clock level, also driven out when the pin is an output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      codec_system_clock <= 1'b0;
    end else if (sys_evt) begin
      codec_system_clock <= !codec_system_clock;
    end
  end

  // -----------------------------------------------------------------
  // slow tick: counts system clock periods
  // -----------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt;   // periods since the last tick
  wire  [TICK_W-1:0] tick_last = slow_tick_rate ? TICK_W'(FAST_DIV - 1) : TICK_W'(SLOW_DIV - 1);
  wire               tick_wrap = sys_rise && (tick_cnt >= tick_last);
  wire  [TICK_W-1:0] next_tick_cnt = tick_wrap ? '0 : tick_cnt + TICK_W'(1);

  // counter cleared while disabled so a restart waits a full period
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt  <= '0;
      slow_tick <= 1'b0;
    end else if (!slow_tick_enable) begin
      tick_cnt  <= '0;
      slow_tick <= 1'b0;
    end else begin
      tick_cnt  <= sys_rise ? next_tick_cnt : tick_cnt;
      slow_tick <= tick_wrap;
    end
  end

  // -----------------------------------------------------------------
  // divider ratio tables, high and low lengths in half periods
  // -----------------------------------------------------------------
  function automatic logic [11:0] bclk_lens(input logic [3:0] code);
    unique case (code)
      4'h0:    bclk_lens = {6'h01, 6'h01};
      4'h1:    bclk_lens = {6'h01, 6'h02};
      4'h2:    bclk_lens = {6'h02, 6'h02};
      4'h3:    bclk_lens = {6'h03, 6'h03};
      4'h4:    bclk_lens = {6'h04, 6'h04};
      4'h5:    bclk_lens = {6'h05, 6'h06};
      4'h6:    bclk_lens = {6'h06, 6'h06};
      4'h7:    bclk_lens = {6'h08, 6'h08};
      4'h8:    bclk_lens = {6'h0B, 6'h0B};
      4'h9:    bclk_lens = {6'h0C, 6'h0C};
      4'hA:    bclk_lens = {6'h0C, 6'h0C};
      4'hB:    bclk_lens = {6'h16, 6'h16};
      4'hC:    bclk_lens = {6'h18, 6'h18};
      default: bclk_lens = {6'h20, 6'h20};
    endcase
  endfunction : bclk_lens

  // reserved aux codes return zero lengths and stop the clock
  function automatic logic [11:0] aux_lens(input logic [2:0] code);
    unique case (code)
      3'h0:    aux_lens = {6'h01, 6'h01};
      3'h1:    aux_lens = {6'h02, 6'h02};
      3'h2:    aux_lens = {6'h03, 6'h03};
      3'h3:    aux_lens = {6'h04, 6'h04};
      3'h4:    aux_lens = {6'h05, 6'h06};
      3'h5:    aux_lens = {6'h06, 6'h06};
      default: aux_lens = {6'h00, 6'h00};
    endcase
  endfunction : aux_lens

  wire [11:0] bclk_sel = bclk_lens(bclk_code);
  wire [11:0] aux_sel  = aux_lens(aux_output_clock_divider);
  wire        aux_run  = aux_sel != 12'h000;

  // bit clock runs only in master mode
  acc_frac_div u_bclk_div (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (master_mode),
    .evt      (sys_evt),
    .hi_len   (bclk_sel[11:6]),
    .lo_len   (bclk_sel[5:0]),
    .clk_out  (bclk_out)
  );

  acc_frac_div u_aux_div (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (aux_run),
    .evt      (sys_evt),
    .hi_len   (aux_sel[11:6]),
    .lo_len   (aux_sel[5:0]),
    .clk_out  (aux_output_clock)
  );

  // -----------------------------------------------------------------
  // pin drive: frame clock select and master clock direction
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_clk_out <= 1'b0;
      frame_clk_oe  <= 1'b0;
      bclk_oe       <= 1'b0;
      mclk_out      <= 1'b0;
      mclk_oe       <= 1'b0;
    end else begin
      frame_clk_out <= frame_clock_record_select ? record_frame_clock : playback_frame_clock;
      frame_clk_oe  <= master_mode;
      bclk_oe       <= master_mode;
      mclk_out      <= mclk_dir && codec_system_clock;
      mclk_oe       <= mclk_dir;
    end
  end

  // -----------------------------------------------------------------
  // checks and covers
  // -----------------------------------------------------------------
  logic [31:0] ast_gap;          // system clock rises between ticks
  logic        ast_seen;         // a tick has been seen under stable rate
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ast_gap  <= 32'h0;
      ast_seen <= 1'b0;
    end else if (!slow_tick_enable || $changed(slow_tick_rate)) begin
      ast_gap  <= 32'h0;
      ast_seen <= 1'b0;
    end else if (slow_tick) begin
      ast_gap  <= {31'h0, sys_rise};
      ast_seen <= 1'b1;
    end else if (sys_rise) begin
      ast_gap  <= ast_gap + 32'h1;
    end
  end

  AST_TICK_OFF: assert property (@(posedge core_clk) disable iff (rst)
    !slow_tick_enable |=> !slow_tick)
    else $error("slow tick while disabled");
  AST_TICK_GAP: assert property (@(posedge core_clk) disable iff (rst)
    (slow_tick && ast_seen) |-> ast_gap == (slow_tick_rate ? FAST_DIV : SLOW_DIV))
    else $error("slow tick period wrong");
  AST_SRC_LOOP: assert property (@(posedge core_clk) disable iff (rst)
    (src_sel == acc_src_loop && $stable(loop_sync[1]) && $stable(src_sel)) |=> $stable(codec_system_clock))
    else $error("system clock moved without a loop edge");
  AST_PREDIV: assert property (@(posedge core_clk) disable iff (rst)
    (prediv && $stable(prediv) && $changed(codec_system_clock)) |-> $past(src_rise))
    else $error("halved clock moved without a source rise");
  AST_BCLK_IDLE: assert property (@(posedge core_clk) disable iff (rst)
    !master_mode |=> !bclk_out)
    else $error("bit clock runs outside master mode");
  AST_AUX_RSVD: assert property (@(posedge core_clk) disable iff (rst)
    aux_output_clock_divider[2:1] == 2'h3 |=> !aux_output_clock)
    else $error("aux clock runs on reserved code");
  AST_FRAME: assert property (@(posedge core_clk) disable iff (rst)
    master_mode |=> frame_clk_oe && frame_clk_out ==
      ($past(frame_clock_record_select) ? $past(record_frame_clock) : $past(playback_frame_clock)))
    else $error("frame clock pin wrong source");
  AST_MCLK_DIR: assert property (@(posedge core_clk) disable iff (rst)
    $changed(mclk_dir) |=> mclk_oe == $past(mclk_dir) ##1 mclk_oe == $past(mclk_dir))
    else $error("master clock pin direction wrong");
  AST_BCLK_RST: assert property (@(posedge core_clk) disable iff (rst)
    $fell(rst) |-> bclk_code == 4'h4)
    else $error("bit clock divider reset value wrong");

  COV_TICK:   cover property (@(posedge core_clk) disable iff (rst) slow_tick);
  COV_BCLK15: cover property (@(posedge core_clk) disable iff (rst) bclk_code == 4'h1 && $rose(bclk_out));
  COV_MCLKO:  cover property (@(posedge core_clk) disable iff (rst) mclk_oe && $rose(mclk_out));
endmodule : acc_clock_control

/* bench/acc_host_model.sv */
// host side model: pin master clock, loop clock and the shared pin level
// assumes core_clk is the block clock; levels move just after falling edges
module acc_host_model (
  // clock
  input  wire logic core_clk,
  // control from the bench
  input  wire logic        pin_run,
  input  wire logic [31:0] pin_half,
  input  wire logic [31:0] loop_half,
  // device drive of the master clock pin
  input  wire logic mclk_out,
  input  wire logic mclk_oe,
  // resolved levels
  output logic      mclk_pin,
  output logic      loop_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  logic host_clk;  // level the host puts on the pin
  int   pin_cnt;   // half period counter, pin clock
  int   loop_cnt;  // half period counter, loop clock

  initial begin
    host_clk = 1'b0;
    loop_clk = 1'b0;
    pin_cnt  = 0;
    loop_cnt = 0;
  end

  // ---------------------------------------------
  // pin clock: stands still low when not running
  // ---------------------------------------------
  always @(negedge core_clk) begin
    if (!pin_run) begin
      host_clk <= 1'b0;
      pin_cnt  <= 0;
    end else if (pin_cnt >= pin_half - 1) begin
      host_clk <= ~host_clk;
      pin_cnt  <= 0;
    end else begin
      pin_cnt <= pin_cnt + 1;
    end
  end

  // loop clock runs free, unrelated to the pin rate
  always @(negedge core_clk) begin
    if (loop_cnt >= loop_half - 1) begin
      loop_clk <= ~loop_clk;
      loop_cnt <= 0;
    end else begin
      loop_cnt <= loop_cnt + 1;
    end
  end

  // pin level: device wins while it drives, so the host stops first
  assign mclk_pin = mclk_oe ? mclk_out : host_clk;
endmodule : acc_host_model

/* bench/audio_codec_clock_control_tb.sv */
// self-checking bench for the codec clock control block
// assumes the package and constants header are compiled ahead of this file
`include "acc_clk_consts.svh"
module audio_codec_clock_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;

  // ---------------------------------------------
  // settings: short tick counts keep the run brief
  // ---------------------------------------------
  localparam int SLOW_T = 16;
  localparam int FAST_T = 4;
  localparam int PIN_H  = 4;   // pin clock half period, cycles
  localparam int LOOP_H = 5;   // loop clock half period, cycles
  localparam int BCLK_H[16] = '{2, 3, 4, 6, 8, 11, 12, 16, 22, 24, 24, 44, 48, 64, 64, 64};
  localparam int AUX_H[8]   = '{2, 4, 6, 8, 11, 12, 0, 0};

  logic core_clk, rst, reg_wr, reg_rd, mclk_in, loop_clk, mclk_out, mclk_oe;
  logic master_mode, play_fc, rec_fc, bclk_out, bclk_oe, frame_clk_out, frame_clk_oe;
  logic sys_clk, aux_clk, slow_tick, pin_run, rd_seen;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [31:0] lfsr;
  logic [15:0] exp_q[$];  // read results still owed
  int          failures, tests_run, p;

  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  acc_clock_control #(.SLOW_DIV(SLOW_T), .FAST_DIV(FAST_T), .TICK_W(22)) u_acc_clock_control (
    .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mclk_in(mclk_in), .frequency_locked_loop(loop_clk),
    .mclk_out(mclk_out), .mclk_oe(mclk_oe), .master_mode(master_mode), .playback_frame_clock(play_fc),
    .record_frame_clock(rec_fc), .bclk_out(bclk_out), .bclk_oe(bclk_oe), .frame_clk_out(frame_clk_out),
    .frame_clk_oe(frame_clk_oe), .codec_system_clock(sys_clk), .aux_output_clock(aux_clk),
    .slow_tick(slow_tick));

  acc_host_model u_acc_host_model (
    .core_clk(core_clk), .pin_run(pin_run), .pin_half(PIN_H), .loop_half(LOOP_H),
    .mclk_out(mclk_out), .mclk_oe(mclk_oe), .mclk_pin(mclk_in), .loop_clk(loop_clk));

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // one request per falling edge; strobes stay up for back to back use
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    lfsr      = lfsr_next(lfsr);
    reg_wr    = w;
    reg_rd    = r;
    reg_addr  = a;
    reg_wdata = w ? d : lfsr[15:0];
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, 1'b1, a, 16'h0000);
    exp_q.push_back(e);
  endtask : rd

  // write both registers, then read both back through the masks
  task automatic cfg(input logic [15:0] dv, input logic [15:0] rt);
    bus(1'b1, 1'b0, `ACC_DIV_CTRL_OFS, dv);
    bus(1'b1, 1'b0, `ACC_ROUTE_CTRL_OFS, rt);
    rd(`ACC_DIV_CTRL_OFS, dv & `ACC_DIV_CTRL_MASK);
    rd(`ACC_ROUTE_CTRL_OFS, rt & `ACC_ROUTE_CTRL_MASK);
    bus(1'b0, 1'b0, 8'h00, 16'h0000);
  endtask : cfg

  function automatic logic sig(input int i);
    case (i)
      0: return sys_clk;
      1: return bclk_out;
      2: return aux_clk;
      3: return mclk_out;
      default: return slow_tick;
    endcase
  endfunction : sig

  // full period between 2nd and 3rd rise; the first may be cut short by a change
  task automatic period(input int i, output int per);
    int n, k, t0;
    logic prev;
    n = 0;
    k = 0;
    t0 = 0;
    per = 0;
    prev = sig(i);
    while (k < 3 && n < 1500) begin
      @(negedge core_clk);
      n++;
      if (prev === 1'b0 && sig(i) === 1'b1) begin
        k++;
        if (k == 2) t0 = n;
        if (k == 3) per = n - t0;
      end
      prev = sig(i);
    end
  endtask : period

  // ---------------------------------------------
  // result monitor: one owed value per read
  // ---------------------------------------------
  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_seen) check({16'h0000, reg_rdata}, {16'h0000, exp_q.pop_front()});
  end

  // watchdog well past the expected run length
  initial begin
    #(60000 * 8);
    failures++;
    complete_run();
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 26'h0};
    {master_mode, play_fc, rec_fc, pin_run, failures, tests_run} = {3'b100, 1'b1, 64'h0};
    lfsr = 32'hFD7BDFB4;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    rd(`ACC_DIV_CTRL_OFS, `ACC_DIV_CTRL_RST);
    rd(`ACC_ROUTE_CTRL_OFS, 16'h0000);
    bus(1'b1, 1'b0, 8'h2A, 16'hFFFF);
    rd(8'h2A, 16'h0000);
    cfg(16'hFFFF, 16'hFFFF);
    // system clock: pin, halved pin, loop
    pin_run = 1'b1;
    cfg(16'h0040, 16'h0000);
    period(0, p);
    check(p, 2 * PIN_H);
    cfg(16'h0140, 16'h0000);
    period(0, p);
    check(p, 4 * PIN_H);
    cfg(16'h0840, 16'h0000);
    period(0, p);
    check(p, 2 * LOOP_H);
    // every bit clock and aux code, system clock half period = PIN_H cycles
    for (int c = 0; c < 16; c++) begin
      cfg(16'(c << 4), 16'h0000);
      period(1, p);
      check(p, BCLK_H[c] * PIN_H);
    end
    for (int c = 0; c < 8; c++) begin
      cfg(16'(c), 16'h0000);
      period(2, p);
      check(p, AUX_H[c] * PIN_H);
    end
    // slow tick at both rates, then stopped
    cfg(16'h8040, 16'h0000);
    period(4, p);
    check(p, SLOW_T * 2 * PIN_H);
    cfg(16'hC040, 16'h0000);
    period(4, p);
    check(p, FAST_T * 2 * PIN_H);
    cfg(16'h4040, 16'h0000);
    period(4, p);
    check(p, 0);
    // pin turned to output, loop feeds it; host lets go first
    pin_run = 1'b0;
    cfg(16'h0840, 16'h0001);
    check(mclk_oe, 1'b1);
    period(3, p);
    check(p, 2 * LOOP_H);
    // frame pin follows the selected frame clock
    for (int s = 0; s < 2; s++) begin
      cfg(16'h0040, 16'(s << 15));
      repeat (12) begin
        @(negedge core_clk);
        lfsr = lfsr_next(lfsr);
        {play_fc, rec_fc} = lfsr[1:0];
        @(negedge core_clk);
        check(frame_clk_out, s ? rec_fc : play_fc);
      end
    end
    check({bclk_oe, frame_clk_oe, mclk_oe}, 3'b110);
    // slave mode: bit clock and frame pin released
    master_mode = 1'b0;
    repeat (3) @(negedge core_clk);
    check({bclk_oe, frame_clk_oe}, 2'b00);
    period(1, p);
    check(p, 0);
    complete_run();
  end
endmodule : audio_codec_clock_control_tb
